// >>> src/idau_regs.svh
// Address map and constants of the indirect data address unit
`ifndef IDAU_REGS_SVH
`define IDAU_REGS_SVH

// Data space geometry
`define IDAU_ADDR_W        12
`define IDAU_DATA_W        8
`define IDAU_NUM_PTR       3
`define IDAU_WIN_SPAN      3'h4

// Pointer byte registers in the data space
`define IDAU_PTR0_LO       12'hFE9
`define IDAU_PTR0_HI       12'hFEA
`define IDAU_PTR1_LO       12'hFE1
`define IDAU_PTR1_HI       12'hFE2
`define IDAU_PTR2_LO       12'hFD9
`define IDAU_PTR2_HI       12'hFDA

// First of the five window locations of each pointer
`define IDAU_WIN0_BASE     12'hFEB
`define IDAU_WIN1_BASE     12'hFE3
`define IDAU_WIN2_BASE     12'hFDB

// Reset value of every pointer
`define IDAU_PTR_RST       12'h000

// Implemented bits of the high pointer byte
`define IDAU_HI_BITS       4

`endif

// >>> src/idau_pkg.sv
// Types shared by the indirect data address unit
package idau_pkg;

  // Side effect chosen by the window location; code equals offset from window base
  typedef enum logic [2:0] {
    IDAU_MODE_INDEXED = 3'b000,
    IDAU_MODE_PREINC  = 3'b001,
    IDAU_MODE_POSTDEC = 3'b010,
    IDAU_MODE_POSTINC = 3'b011,
    IDAU_MODE_PLAIN   = 3'b100
  } idau_mode_t;

  // Where a resolved access lands
  typedef enum logic [1:0] {
    IDAU_KIND_RAM  = 2'b00,
    IDAU_KIND_PTR  = 2'b01,
    IDAU_KIND_SELF = 2'b10
  } idau_kind_t;

  // Access request from the execution logic
  typedef struct packed {
    logic        write;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  working_register;
  } idau_req_t;

  // Access toward data RAM
  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } idau_ram_t;

  // Result of decoding an address against the window locations
  typedef struct packed {
    logic       hit;
    logic [1:0] idx;
    idau_mode_t mode;
  } idau_win_t;

endpackage

// >>> src/idau_ptr_arith.sv
// Address and next-pointer arithmetic for one pointer
`timescale 1ns/1ps
`default_nettype none

module idau_ptr_arith #(
  parameter int AW = 12
) (
  input  wire logic [AW-1:0]         ptr_i,
  input  wire idau_pkg::idau_mode_t  mode_i,
  input  wire logic [7:0]            working_register_i,
  output logic      [AW-1:0]         addr_o,
  output logic      [AW-1:0]         nxt_ptr_o
);

  logic [AW-1:0] ptr_inc;
  logic [AW-1:0] ptr_dec;
  logic [AW-1:0] working_register_sx;

  // Full-width arithmetic so low-byte carry and borrow reach the high byte
  assign ptr_inc = ptr_i + {{(AW-1){1'b0}}, 1'b1}; // RULE12
  assign ptr_dec = ptr_i - {{(AW-1){1'b0}}, 1'b1}; // RULE12
  // Signed working register, sum wraps in the address space
  assign working_register_sx = {{(AW-8){working_register_i[7]}}, working_register_i}; // RULE14

  // Access address and pointer after the access for each mode
  always_comb begin
    addr_o    = ptr_i;
    nxt_ptr_o = ptr_i;
    unique case (mode_i)
      idau_pkg::IDAU_MODE_PLAIN: begin
        addr_o    = ptr_i; // RULE6
        nxt_ptr_o = ptr_i;
      end
      idau_pkg::IDAU_MODE_POSTDEC: begin
        addr_o    = ptr_i; // RULE7
        nxt_ptr_o = ptr_dec;
      end
      idau_pkg::IDAU_MODE_POSTINC: begin
        addr_o    = ptr_i; // RULE8
        nxt_ptr_o = ptr_inc;
      end
      idau_pkg::IDAU_MODE_PREINC: begin
        addr_o    = ptr_inc; // RULE9
        nxt_ptr_o = ptr_inc;
      end
      idau_pkg::IDAU_MODE_INDEXED: begin
        addr_o    = ptr_i + working_register_sx; // RULE10
        nxt_ptr_o = ptr_i;
      end
      default: begin
        addr_o    = ptr_i;
        nxt_ptr_o = ptr_i;
      end
    endcase
  end

endmodule

`default_nettype wire

// >>> src/idau_top.sv
// Indirect data address unit: three pointers and their window locations
`timescale 1ns/1ps
`default_nettype none
`include "idau_regs.svh"

// Functional notes
// RULE1 - Three 12-bit pointers, high and low bytes
// RULE2 - Window access reaches RAM at pointer address
// RULE3 - Indirect read of a window returns zero
// RULE4 - Indirect write to a window is discarded
// RULE5 - Five window locations select pointer side effect
// RULE6 - Plain window leaves pointer unchanged
// RULE7 - Post-decrement: use pointer, then subtract one
// RULE8 - Post-increment: use pointer, then add one
// RULE9 - Pre-increment: add one, then use pointer
// RULE10 - Indexed: pointer plus signed working register
// RULE11 - Pointer stepping never touches status flags
// RULE12 - Stepping spans all twelve pointer bits
// RULE13 - Write to own pointer byte beats stepping
// RULE14 - Index sign-extended, wraps modulo 4096
// RULE15 - Pointer bytes directly accessible, high nibble zero
module idau_top (
  input  wire logic                clk_sys_i,
  input  wire logic                resetn_i,
  input  wire logic                req_valid_i,
  input  wire idau_pkg::idau_req_t req_i,
  output idau_pkg::idau_ram_t      ram_o,
  input  wire logic [7:0]          ram_rdata_i,
  output logic                     rsp_valid_o,
  output logic [7:0]               rsp_data_o,
  output logic                     rsp_zero_o,
  output logic                     rsp_nop_o
);

  localparam int NP = `IDAU_NUM_PTR;
  localparam int AW = `IDAU_ADDR_W;
  localparam int HB = `IDAU_HI_BITS;

  logic                       rst_meta_ff;
  logic                       rst_n_ff;
  logic [AW-1:0]              ptr_ff [NP];
  logic [AW-1:0]              nxt_ptr [NP];
  logic [AW-1:0]              step_ptr [NP];
  logic [AW-1:0]              win_addr [NP];
  idau_pkg::idau_win_t        req_win;
  idau_pkg::idau_win_t        eff_win;
  logic [AW-1:0]              eff_addr;
  logic                       tgt_ptr_hit;
  logic [1:0]                 tgt_ptr_idx;
  logic                       tgt_hi;
  idau_pkg::idau_kind_t       kind;
  logic [7:0]                 local_data;
  idau_pkg::idau_ram_t        ram_ff;
  logic                       s1_valid_ff;
  logic                       s1_write_ff;
  idau_pkg::idau_kind_t       s1_kind_ff;
  logic [7:0]                 s1_data_ff;
  logic                       s2_valid_ff;
  logic                       s2_write_ff;
  idau_pkg::idau_kind_t       s2_kind_ff;
  logic [7:0]                 s2_data_ff;
  logic                       rsp_valid_ff;
  logic [7:0]                 rsp_data_ff;
  logic                       rsp_zero_ff;
  logic                       rsp_nop_ff;

  // First window location of pointer n
  function automatic logic [AW-1:0] win_base(input int n);
    unique case (n)
      0:       win_base = `IDAU_WIN0_BASE;
      1:       win_base = `IDAU_WIN1_BASE;
      default: win_base = `IDAU_WIN2_BASE;
    endcase
  endfunction

  // Data-space address of a pointer byte
  function automatic logic [AW-1:0] ptr_addr(input int n, input logic hi);
    unique case (n)
      0:       ptr_addr = hi ? `IDAU_PTR0_HI : `IDAU_PTR0_LO;
      1:       ptr_addr = hi ? `IDAU_PTR1_HI : `IDAU_PTR1_LO;
      default: ptr_addr = hi ? `IDAU_PTR2_HI : `IDAU_PTR2_LO;
    endcase
  endfunction

  // Which pointer and side effect, if any, an address selects
  function automatic idau_pkg::idau_win_t win_decode(input logic [AW-1:0] a);
    idau_pkg::idau_win_t w;
    logic [AW-1:0]       off;
    w = '0;
    for (int n = 0; n < NP; n++) begin
      off = a - win_base(n);
      if (off <= {{(AW-3){1'b0}}, `IDAU_WIN_SPAN}) begin
        w.hit  = 1'b1; // RULE5
        w.idx  = 2'(n);
        w.mode = idau_pkg::idau_mode_t'(off[2:0]);
      end
    end
    return w;
  endfunction

  // Reset release through two flops; the async edge only loads constants
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // One arithmetic slice per pointer
  for (genvar g = 0; g < NP; g++) begin : g_ptr
    idau_ptr_arith #(
      .AW (AW)
    ) u_arith (
      .ptr_i     (ptr_ff[g]),
      .mode_i    (req_win.mode),
      .working_register_i    (req_i.working_register),
      .addr_o    (win_addr[g]),
      .nxt_ptr_o (step_ptr[g])
    );
  end

  // Resolve the request into a final target
  always_comb begin
    req_win     = win_decode(req_i.addr);
    eff_addr    = req_win.hit ? win_addr[req_win.idx] : req_i.addr; // RULE2
    eff_win     = win_decode(eff_addr);
    tgt_ptr_hit = 1'b0;
    tgt_ptr_idx = 2'h0;
    tgt_hi      = 1'b0;
    for (int n = 0; n < NP; n++) begin
      if (eff_addr == ptr_addr(n, 1'b0) || eff_addr == ptr_addr(n, 1'b1)) begin
        tgt_ptr_hit = 1'b1; // RULE15
        tgt_ptr_idx = 2'(n);
        tgt_hi      = (eff_addr == ptr_addr(n, 1'b1));
      end
    end
    // A window can only be the final target when reached through a pointer
    if (eff_win.hit) begin
      kind = idau_pkg::IDAU_KIND_SELF; // RULE3 RULE4
    end else if (tgt_ptr_hit) begin
      kind = idau_pkg::IDAU_KIND_PTR;
    end else begin
      kind = idau_pkg::IDAU_KIND_RAM;
    end
    // Upper nibble of the high byte reads zero
    local_data = 8'h00;
    if (kind == idau_pkg::IDAU_KIND_PTR) begin
      local_data = tgt_hi ? {{(8-HB){1'b0}}, ptr_ff[tgt_ptr_idx][AW-1:8]}
                          : ptr_ff[tgt_ptr_idx][7:0]; // RULE15
    end
  end

  // Next pointer values: stepping first, then a byte write overrides it
  always_comb begin
    for (int n = 0; n < NP; n++) begin
      nxt_ptr[n] = ptr_ff[n];
      if (req_valid_i && req_win.hit && req_win.idx == 2'(n)) begin
        nxt_ptr[n] = step_ptr[n]; // RULE11
      end
      if (req_valid_i && req_i.write && kind == idau_pkg::IDAU_KIND_PTR
          && tgt_ptr_idx == 2'(n)) begin
        // The written byte wins; the other byte keeps its pre-access value
        nxt_ptr[n] = tgt_hi ? {req_i.wdata[HB-1:0], ptr_ff[n][7:0]}
                            : {ptr_ff[n][AW-1:8], req_i.wdata}; // RULE13
      end
    end
  end

  // Pointer storage, cleared at reset
  always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int n = 0; n < NP; n++) begin
        ptr_ff[n] <= `IDAU_PTR_RST; // RULE1
      end
    end else begin
      for (int n = 0; n < NP; n++) begin
        ptr_ff[n] <= nxt_ptr[n]; // RULE1 RULE12
      end
    end
  end

  // RAM access stage; self-target and pointer accesses never reach RAM
  always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ram_ff <= '0;
    end else begin
      ram_ff.req   <= req_valid_i && (kind == idau_pkg::IDAU_KIND_RAM); // RULE2 RULE4
      ram_ff.we    <= req_valid_i && req_i.write && (kind == idau_pkg::IDAU_KIND_RAM);
      ram_ff.addr  <= eff_addr; // RULE2
      ram_ff.wdata <= req_i.wdata;
    end
  end

  // Pipeline carrying the kind and local data past the RAM latency
  always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      s1_valid_ff <= 1'b0;
      s1_write_ff <= 1'b0;
      s1_kind_ff  <= idau_pkg::IDAU_KIND_RAM;
      s1_data_ff  <= 8'h00;
      s2_valid_ff <= 1'b0;
      s2_write_ff <= 1'b0;
      s2_kind_ff  <= idau_pkg::IDAU_KIND_RAM;
      s2_data_ff  <= 8'h00;
    end else begin
      s1_valid_ff <= req_valid_i;
      s1_write_ff <= req_i.write;
      s1_kind_ff  <= kind;
      s1_data_ff  <= local_data;
      s2_valid_ff <= s1_valid_ff;
      s2_write_ff <= s1_write_ff;
      s2_kind_ff  <= s1_kind_ff;
      s2_data_ff  <= s1_data_ff;
    end
  end

  // Response; only a self-target read raises the zero indication
  always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 8'h00;
      rsp_zero_ff  <= 1'b0;
      rsp_nop_ff   <= 1'b0;
    end else begin
      rsp_valid_ff <= s2_valid_ff;
      rsp_data_ff  <= (s2_kind_ff == idau_pkg::IDAU_KIND_RAM) ? ram_rdata_i
                                                             : s2_data_ff; // RULE3
      rsp_zero_ff  <= s2_valid_ff && !s2_write_ff
                      && (s2_kind_ff == idau_pkg::IDAU_KIND_SELF); // RULE3
      rsp_nop_ff   <= s2_valid_ff && s2_write_ff
                      && (s2_kind_ff == idau_pkg::IDAU_KIND_SELF); // RULE4
    end
  end

  assign ram_o       = ram_ff;
  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_data_o  = rsp_data_ff;
  assign rsp_zero_o  = rsp_zero_ff;
  assign rsp_nop_o   = rsp_nop_ff;

endmodule

`default_nettype wire

// >>> bench/idau_ram_model.sv
// Synchronous data RAM model on the far side of the indirect address unit
`timescale 1ns/1ps
`default_nettype none
module idau_ram_model (
  input  wire logic                clk_i,
  input  wire idau_pkg::idau_ram_t ram_i,
  output logic      [7:0]          rdata_o
);
  logic [7:0] mem [4096];
  logic [7:0] q_ff   = 8'h00;
  logic       vld_ff = 1'b0;

  // Known fill so the bench can predict every read: low byte xor upper bits
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 4);
    end
  end

  // One-cycle read latency; stale data is inverted so a late sample is caught
  always @(posedge clk_i) begin
    vld_ff <= ram_i.req && !ram_i.we;
    if (ram_i.req && ram_i.we) begin
      mem[ram_i.addr] <= ram_i.wdata;
    end
    if (ram_i.req && !ram_i.we) begin
      q_ff <= mem[ram_i.addr];
    end
  end
  assign rdata_o = vld_ff ? q_ff : ~q_ff;
endmodule
`default_nettype wire

// >>> bench/idau_top_properties.sv
// Concurrent checks on the ports of the indirect data address unit
`timescale 1ns/1ps
`default_nettype none
`include "idau_regs.svh"
module idau_top_properties (
  input wire logic                clk_sys_i,
  input wire logic                resetn_i,
  input wire logic                req_valid_i,
  input wire idau_pkg::idau_req_t req_i,
  input wire idau_pkg::idau_ram_t ram_o,
  input wire logic [7:0]          ram_rdata_i,
  input wire logic                rsp_valid_o,
  input wire logic [7:0]          rsp_data_o,
  input wire logic                rsp_zero_o,
  input wire logic                rsp_nop_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // Direct access to any pointer byte
  sequence s_ptr_byte;
    req_valid_i && (req_i.addr inside {`IDAU_PTR0_LO, `IDAU_PTR0_HI, `IDAU_PTR1_LO,
                                       `IDAU_PTR1_HI, `IDAU_PTR2_LO, `IDAU_PTR2_HI});
  endsequence
  sequence s_ram_rd;
    ram_o.req && !ram_o.we;
  endsequence
  sequence s_postinc0;
    req_valid_i && !req_i.write && req_i.addr == `IDAU_WIN0_BASE + 12'h003;
  endsequence

  chk_rsp_latency: assert property (req_valid_i |-> ##3 rsp_valid_o)
    else $error("response missing three cycles after request");
  chk_rsp_cause: assert property (rsp_valid_o |-> $past(req_valid_i, 3))
    else $error("response without request");
  chk_ram_cause: assert property (ram_o.req |->
                                  $past(req_valid_i) && ram_o.we == $past(req_i.write))
    else $error("ram access not caused by request");
  chk_wr_data: assert property (ram_o.req && ram_o.we |->
                                ram_o.wdata == $past(req_i.wdata))
    else $error("ram write data differs from request");
  chk_zero_read: assert property (rsp_zero_o |-> rsp_valid_o && rsp_data_o == 8'h00 && !rsp_nop_o
                                  && !$past(req_i.write, 3))
    else $error("zero flag with bad data or on a write");
  chk_nop_write: assert property (rsp_nop_o |-> rsp_valid_o && $past(req_i.write, 3)
                                  && !$past(ram_o.req, 2))
    else $error("discarded write reached ram");
  chk_ptr_no_ram: assert property (s_ptr_byte |=> !ram_o.req)
    else $error("pointer byte access went to ram");
  chk_rd_data: assert property (s_ram_rd |-> ##2
                                (rsp_valid_o && rsp_data_o == $past(ram_rdata_i)))
    else $error("read data not returned from ram");
  chk_postinc_pair: assert property (s_postinc0 ##1 s_postinc0 |=> (ram_o.req && $past(ram_o.req))
                                     |-> ram_o.addr == $past(ram_o.addr) + 12'h001)
    else $error("back to back post increment did not step");
endmodule
`default_nettype wire

// >>> bench/tb_indirect_data_address_unit.sv
// Self-checking bench for the indirect data address unit
`timescale 1ns/1ps
`default_nettype none
`define IDAU_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_indirect_data_address_unit;
  // Row: write, address, write data, working register, {ram, zero, nop, 0}, ram addr, read data
  typedef struct packed {
    logic [3:0]  wr;
    logic [11:0] addr;
    logic [7:0]  wd;
    logic [7:0]  working_register;
    logic [3:0]  fl;
    logic [11:0] ra;
    logic [7:0]  rd;
  } idau_row_t;

  logic                clk_sys_i;
  logic                resetn_i;
  logic                req_valid_i;
  idau_pkg::idau_req_t req_i;
  idau_pkg::idau_ram_t ram_o;
  logic [7:0]          ram_rdata_i;
  logic                rsp_valid_o;
  logic [7:0]          rsp_data_o;
  logic                rsp_zero_o;
  logic                rsp_nop_o;
  int                  mismatches = 0;
  int                  tests_run  = 0;
  int                  cycles     = 0;

  // Pointer setup, every window mode, carries, wrap, self target and own-byte write
  idau_row_t rows [26] = '{
    56'h1_FEA_01_00_0_000_00, 56'h1_FE9_FF_00_0_000_00, 56'h0_FEE_00_00_8_1FF_E0,
    56'h0_FE9_00_00_0_000_00, 56'h0_FEA_00_00_0_000_02, 56'h0_FEC_00_00_8_201_21,
    56'h0_FED_00_00_8_201_21, 56'h0_FEF_00_00_8_200_20, 56'h0_FEB_00_80_8_180_98,
    56'h0_FEF_00_00_8_200_20, 56'h1_FEF_A5_00_8_200_00, 56'h0_FEF_00_00_8_200_A5,
    56'h0_FE3_00_FF_8_FFF_00, 56'h0_FE5_00_00_8_000_00, 56'h0_FE2_00_00_0_000_0F,
    56'h0_FE1_00_00_0_000_FF, 56'h0_FE6_00_00_8_FFF_00, 56'h0_FE7_00_00_8_000_00,
    56'h1_FDA_FF_00_0_000_00, 56'h1_FD9_DB_00_0_000_00, 56'h0_FDF_00_00_4_000_00,
    56'h1_FDF_77_00_2_000_00, 56'h1_FD9_D9_00_0_000_00, 56'h1_FDE_40_00_0_000_00,
    56'h0_FD9_00_00_0_000_40, 56'h0_FDA_00_00_0_000_0F};

  idau_top dut (
    .clk_sys_i   (clk_sys_i),
    .resetn_i    (resetn_i),
    .req_valid_i (req_valid_i),
    .req_i       (req_i),
    .ram_o       (ram_o),
    .ram_rdata_i (ram_rdata_i),
    .rsp_valid_o (rsp_valid_o),
    .rsp_data_o  (rsp_data_o),
    .rsp_zero_o  (rsp_zero_o),
    .rsp_nop_o   (rsp_nop_o)
  );

  idau_ram_model ram (
    .clk_i   (clk_sys_i),
    .ram_i   (ram_o),
    .rdata_o (ram_rdata_i)
  );

  // 250 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One access, checked at the ram cycle and at the fixed response cycle
  task automatic acc(input idau_row_t r);
    req_valid_i = 1'b1;
    req_i       = '{r.wr[0], r.addr, r.wd, r.working_register};
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    `IDAU_CHK(ram_o.req, r.fl[3]);
    if (r.fl[3]) begin
      `IDAU_CHK(ram_o.addr, r.ra);
      `IDAU_CHK(ram_o.we, r.wr[0]);
      if (r.wr[0]) `IDAU_CHK(ram_o.wdata, r.wd);
    end
    repeat (2) @(negedge clk_sys_i);
    `IDAU_CHK(rsp_valid_o, 1'b1);
    `IDAU_CHK(rsp_zero_o, r.fl[2]);
    `IDAU_CHK(rsp_nop_o, r.fl[1]);
    if (!r.wr[0]) `IDAU_CHK(rsp_data_o, r.rd);
  endtask

  // Hang guard: the run needs about 110 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    resetn_i    = 1'b0;
    req_valid_i = 1'b0;
    req_i       = '0;
    repeat (12) @(negedge clk_sys_i);
    `IDAU_CHK(rsp_valid_o, 1'b0);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    foreach (rows[i]) acc(rows[i]);
    // Back to back post increment: second access sees the stepped pointer
    req_valid_i = 1'b1;
    req_i       = '{1'b0, 12'hFEE, 8'h00, 8'h00};
    @(negedge clk_sys_i);
    `IDAU_CHK(ram_o.addr, 12'h200);
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    `IDAU_CHK(ram_o.addr, 12'h201);
    @(negedge clk_sys_i);
    // Location 200 still holds the byte written through the plain window earlier
    `IDAU_CHK(rsp_data_o, 8'hA5);
    @(negedge clk_sys_i);
    `IDAU_CHK(rsp_data_o, 8'h21);
    // Reset in mid-run clears the pointers and silences the outputs
    resetn_i = 1'b0;
    @(negedge clk_sys_i);
    `IDAU_CHK(ram_o.req, 1'b0);
    repeat (3) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    acc(56'h0_FEA_00_00_0_000_00);
    acc(56'h0_FE9_00_00_0_000_00);
    wrap_up();
  end
endmodule

bind idau_top idau_top_properties u_props (
  .clk_sys_i   (clk_sys_i),
  .resetn_i    (resetn_i),
  .req_valid_i (req_valid_i),
  .req_i       (req_i),
  .ram_o       (ram_o),
  .ram_rdata_i (ram_rdata_i),
  .rsp_valid_o (rsp_valid_o),
  .rsp_data_o  (rsp_data_o),
  .rsp_zero_o  (rsp_zero_o),
  .rsp_nop_o   (rsp_nop_o)
);
`default_nettype wire
